// ---- verification/drce_host.sv ----
/* Host partner: sends opcode and parameter bytes, strobes reads and
   supplies memory read data. Assumes rising-edge sampling by the design. */
`timescale 1ns/1ps
module drce_host (
   // Clock
   input wire clk_i,
   // Host byte port
   output reg stb_o,
   output reg dc_o,
   output reg [7:0] byte_o,
   output reg rd_stb_o,
   // Memory read data
   output reg [7:0] rdata_o
);
   integer k;
   initial begin
      stb_o = 1'b0;
      dc_o = 1'b1;
      byte_o = 8'h00;
      rd_stb_o = 1'b0;
      rdata_o = 8'h00;
   end
   // Opcode first, then parameters or RAM data back to back
   task xfer(input reg [7:0] q[$]);
      begin
         @(posedge clk_i);
         #1;
         for (k = 0; k < q.size(); k = k + 1) begin
            stb_o = 1'b1;
            dc_o = (k != 0);
            byte_o = q[k];
            @(posedge clk_i);
            #1;
         end
         stb_o = 1'b0;
         dc_o = ~dc_o;
         byte_o = ~byte_o;
      end
   endtask
   task rd(input reg [7:0] v);
      begin
         @(posedge clk_i);
         #1;
         rd_stb_o = 1'b1;
         rdata_o = v;
         @(posedge clk_i);
         #1;
         rd_stb_o = 1'b0;
         repeat (3) @(posedge clk_i);
         #1;
         rdata_o = ~v;
      end
   endtask
endmodule

// ---- verification/drce_props.sv ----
/* Port checker for drce_top, bound to every instance.
   Assumes one-cycle host strobes synchronous to MCLK_I. */
`timescale 1ns/1ps
module drce_props (
   // Clock, reset and host port
   input wire MCLK_I,
   input wire RST_N_I,
   input wire BYTE_STB_I,
   input wire DC_I,
   input wire [7:0] BYTE_I,
   input wire RD_STB_I,
   // Watched outputs
   input wire MEM_WR_O,
   input wire MEM_RD_O,
   input wire [7:0] MEM_WDATA_O,
   input wire BUSY_O,
   input wire FILL_EN_O,
   input wire VERT_INC_O,
   input wire [7:0] HS_OFFSET_O,
   input wire HS_RUN_O,
   input wire [7:0] START_LINE_O
);
   reg wr_mode_reg;
   reg rd_mode_reg;
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (!RST_N_I);
   // ==========================================================
   // RAM stream mode as opened by the last opcode
   always @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         wr_mode_reg <= 1'b0;
         rd_mode_reg <= 1'b0;
      end else if (BYTE_STB_I && !DC_I && !BUSY_O) begin
         wr_mode_reg <= (BYTE_I == 8'h5c);
         rd_mode_reg <= (BYTE_I == 8'h5d);
      end
   end
   sequence data_in_s;
      wr_mode_reg && BYTE_STB_I && DC_I;
   endsequence
   sequence read_req_s;
      rd_mode_reg && RD_STB_I;
   endsequence
   // ==========================================================
   // Properties
   wr_pulse_a: assert property (data_in_s |=> MEM_WR_O && MEM_WDATA_O == $past(BYTE_I))
      else $error("data byte not written");
   rd_pulse_a: assert property (read_req_s |=> MEM_RD_O)
      else $error("read strobe gave no memory read");
   busy_read_a: assert property (BUSY_O |-> !MEM_RD_O)
      else $error("memory read during drawing");
   busy_start_a: assert property ($rose(BUSY_O) |-> $past(BYTE_STB_I && DC_I, 2))
      else $error("drawing started without parameter byte");
   fill_cause_a: assert property ($changed(FILL_EN_O) |-> $past(BYTE_STB_I && DC_I))
      else $error("fill enable changed without parameter");
   remap_cause_a: assert property ($changed(VERT_INC_O) |-> $past(BYTE_STB_I && DC_I, 2))
      else $error("increment mode changed without parameter");
   scroll_max_a: assert property (HS_OFFSET_O <= 8'h7c)
      else $error("scroll offset above limit");
   run_need_a: assert property (HS_RUN_O |-> HS_OFFSET_O != 8'h00)
      else $error("scroll runs with zero offset");
   line_max_a: assert property (START_LINE_O <= 8'h83)
      else $error("start line above limit");
endmodule

bind drce_top drce_props chk_u (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .BYTE_STB_I(BYTE_STB_I), .DC_I(DC_I),
   .BYTE_I(BYTE_I), .RD_STB_I(RD_STB_I), .MEM_WR_O(MEM_WR_O), .MEM_RD_O(MEM_RD_O), .MEM_WDATA_O(MEM_WDATA_O),
   .BUSY_O(BUSY_O), .FILL_EN_O(FILL_EN_O), .VERT_INC_O(VERT_INC_O), .HS_OFFSET_O(HS_OFFSET_O),
   .HS_RUN_O(HS_RUN_O), .START_LINE_O(START_LINE_O));

// ---- verification/tb.sv ----
/* Self-checking bench for drce_top with a host partner model.
   Assumes MCLK_I at 10 MHz and a pointer model kept in the bench. */
`timescale 1ns/1ps
module tb;
   reg MCLK_I;
   reg RST_N_I;
   reg BUS16_I;
   reg DISPLAY_ON_I;
   wire stb, dc, rs_stb, mwr, mrd, busy, fen, rcp, xw, vert, crev, cswp, b9, comr, coms, wide, run;
   wire [1:0] depth, spd;
   wire [7:0] bt, rdat, mcol, mrow, wdat, rdd, dop, rad, dcol, drow, sl, hoff, hrow, hcnt;
   wire [15:0] lc, fc;
   integer errors, comparisons, seed, pc, pr, cs, ce, rs, re, vm, i, nacc, npush;
   reg [23:0] exp_q[$];
   reg [7:0] r;
   reg [7:0] q[$];
   drce_host host_u (.clk_i(MCLK_I), .stb_o(stb), .dc_o(dc), .byte_o(bt), .rd_stb_o(rs_stb), .rdata_o(rdat));
   drce_top dut_u (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .BYTE_STB_I(stb), .DC_I(dc), .BYTE_I(bt),
      .RD_STB_I(rs_stb), .BUS16_I(BUS16_I), .DISPLAY_ON_I(DISPLAY_ON_I), .MEM_RDATA_I(rdat), .MEM_WR_O(mwr),
      .MEM_RD_O(mrd), .MEM_COL_O(mcol), .MEM_ROW_O(mrow), .MEM_WDATA_O(wdat), .RD_DATA_O(rdd), .BUSY_O(busy),
      .DRAW_OP_O(dop), .LINE_COLOR_O(lc), .FILL_COLOR_O(fc), .CIRCLE_RADIUS_O(rad), .COPY_DST_COL_O(dcol),
      .COPY_DST_ROW_O(drow), .FILL_EN_O(fen), .REV_COPY_O(rcp), .XWRAP_O(xw), .VERT_INC_O(vert),
      .COL_REV_O(crev), .CLR_SWAP_O(cswp), .BUS9_O(b9), .COM_REV_O(comr), .COM_SPLIT_O(coms), .DEPTH_O(depth),
      .WIDE_PACK_O(wide), .START_LINE_O(sl), .HS_OFFSET_O(hoff), .HS_ROW_O(hrow), .HS_COUNT_O(hcnt),
      .HS_SPEED_O(spd), .HS_RUN_O(run));
   // ==========================================================
   // Helpers
   task check(input string n, input logic [23:0] seen, input logic [23:0] expv);
      begin
         comparisons = comparisons + 1;
         if (seen !== expv) begin
            errors = errors + 1;
            $display("wrong value %s expected %h seen %h", n, expv, seen);
         end
      end
   endtask
   task finish_test;
      begin
         $display("errors %0d comparisons %0d", errors, comparisons);
         if (errors == 0 && comparisons > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   task adv;
      begin
         if (vm == 0) begin
            if (pc == ce) pr = (pr == re) ? rs : pr + 1;
            pc = (pc == ce) ? cs : pc + 1;
         end else begin
            if (pr == re) pc = (pc == ce) ? cs : pc + 1;
            pr = (pr == re) ? rs : pr + 1;
         end
      end
   endtask
   task win(input integer c0, input integer c1, input integer r0, input integer r1);
      begin
         host_u.xfer('{8'h15, c0[7:0], c1[7:0]});
         host_u.xfer('{8'h75, r0[7:0], r1[7:0]});
         cs = c0; ce = c1; rs = r0; re = r1; pc = c0; pr = r0;
      end
   endtask
   task wstream(input integer n);
      integer k;
      reg [7:0] b;
      begin
         q = '{8'h5c};
         for (k = 0; k < n; k = k + 1) begin
            b = $random(seed);
            q.push_back(b);
            exp_q.push_back({pc[7:0], pr[7:0], b});
            npush = npush + 1;
            adv;
         end
         host_u.xfer(q);
         repeat (3) @(posedge MCLK_I);
      end
   endtask
   task draw(input reg [7:0] cq[$]);
      integer k;
      begin
         host_u.xfer(cq);
         k = 0;
         while (busy !== 1'b1 && k < 10) begin
            @(posedge MCLK_I);
            k = k + 1;
         end
         check("busy rise", busy, 1);
         host_u.xfer('{8'ha1, 8'h05});
         while (busy !== 1'b0 && k < 400) begin
            @(posedge MCLK_I);
            k = k + 1;
         end
         check("busy fall", busy, 0);
         @(posedge MCLK_I);
         check("line kept", sl, 131);
      end
   endtask
   // ==========================================================
   // RAM access monitor
   always @(posedge MCLK_I) begin
      if (RST_N_I && (mwr === 1'b1 || mrd === 1'b1) && busy === 1'b0) begin
         nacc = nacc + 1;
         if (exp_q.size() > 0) check("ram access", {mcol, mrow, (mwr ? wdat : 8'h00)}, exp_q.pop_front());
      end
   end
   initial begin
      MCLK_I = 1'b0;
      forever #50 MCLK_I = ~MCLK_I;
   end
   initial begin
      #(20000 * 100);
      errors = errors + 1;
      finish_test;
   end
   // ==========================================================
   // Main sequence
   initial begin
      errors = 0; comparisons = 0; seed = 50377; nacc = 0; npush = 0; vm = 0;
      RST_N_I = 1'b0; BUS16_I = 1'b0; DISPLAY_ON_I = 1'b1;
      repeat (2) @(posedge MCLK_I);
      #1 RST_N_I = 1'b1;
      repeat (3) @(posedge MCLK_I);
      check("depth rst", depth, 2'b01);
      check("cfg rst", {fen, rcp, xw, vert, crev, sl}, 0);
      for (i = 0; i < 4; i = i + 1) begin
         r = {i[1:0], 6'h00} | ($random(seed) & 8'h3f);
         #1 BUS16_I = $random(seed);
         host_u.xfer('{8'ha0, r});
         repeat (3) @(posedge MCLK_I);
         check("remap", {depth, coms, comr, b9, cswp, crev, vert}, r);
         check("wide", wide, BUS16_I & (i == 3));
      end
      r = $random(seed);
      host_u.xfer('{8'h92, r});
      repeat (2) @(posedge MCLK_I);
      check("fill", {xw, rcp, fen}, {r[5], r[4], r[0]});
      host_u.xfer('{8'ha1, 8'd131});
      host_u.xfer('{8'ha1, 8'd132});
      repeat (2) @(posedge MCLK_I);
      check("start line", sl, 131);
      for (i = 0; i < 4; i = i + 1) begin
         host_u.xfer('{8'h96, 8'd124, 8'd3, 8'd10, 8'h00, i[7:0]});
         host_u.xfer('{8'h96, 8'd125, 8'd1, 8'd1, 8'h00, 8'h00});
         repeat (2) @(posedge MCLK_I);
         check("scroll", {hoff, hrow, hcnt}, {8'd124, 8'd3, 8'd10});
         check("speed", spd, i[1:0]);
         check("run", run, 1);
      end
      #1 DISPLAY_ON_I = 1'b0;
      repeat (2) @(posedge MCLK_I);
      check("run off", run, 0);
      host_u.xfer('{8'ha0, 8'h40});
      vm = 0;
      win(2, 4, 1, 2);
      wstream(8);
      host_u.xfer('{8'ha0, 8'h41});
      vm = 1;
      win(5, 6, 3, 5);
      wstream(8);
      host_u.xfer('{8'h5d});
      for (i = 0; i < 3; i = i + 1) begin
         r = $random(seed);
         exp_q.push_back({pc[7:0], pr[7:0], 8'h00});
         npush = npush + 1;
         adv;
         host_u.rd(r);
         check("read data", rdd, r);
      end
      draw('{8'h84, 8'd1, 8'd1, 8'd3, 8'd2, 8'hf8, 8'h1f, 8'h07, 8'he0});
      check("colours", {lc, dop}, {16'hf81f, 8'h84});
      check("fill colour", fc, 16'h07e0);
      draw('{8'h86, 8'd10, 8'd10, 8'd2, 8'h12, 8'h34, 8'h56, 8'h78});
      check("circle", {rad, lc}, {8'd2, 16'h1234});
      check("circle fill", fc, 16'h5678);
      draw('{8'h8a, 8'd1, 8'd1, 8'd2, 8'd2, 8'd5, 8'd6});
      check("copy", {dcol, drow, dop}, {8'd5, 8'd6, 8'h8a});
      draw('{8'h8c, 8'd1, 8'd1, 8'd2, 8'd2});
      check("dim", dop, 8'h8c);
      draw('{8'h8e, 8'd1, 8'd1, 8'd2, 8'd2});
      check("clear", dop, 8'h8e);
      repeat (3) @(posedge MCLK_I);
      check("accesses", nacc, npush);
      finish_test;
   end
endmodule

// ---- verilog/drce_draw.v ----
/*
 Drawing sequencer for graphics assist commands: walks the target
 rectangle one pixel per clock. Assumes parameters stay stable while busy.
*/
`timescale 1ns/1ps
`include "drce_map.vh"
module drce_draw (
   // Clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // Start
   input wire start_i,
   input wire [7:0] c0_i,
   input wire [7:0] r0_i,
   input wire [7:0] c1_i,
   input wire [7:0] r1_i,
   // Progress
   output reg busy_o,
   output reg [7:0] col_o,
   output reg [7:0] row_o
);
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_o <= 1'b0;
         col_o <= `DRCE_RST_ZERO;
         row_o <= `DRCE_RST_ZERO;
      end else if (start_i && !busy_o) begin
         busy_o <= 1'b1;
         col_o <= c0_i;
         row_o <= r0_i;
      end else if (busy_o) begin
         if (col_o >= c1_i) begin
            col_o <= c0_i;
            if (row_o >= r1_i) begin
               busy_o <= 1'b0;
            end else begin
               row_o <= row_o + 8'h01;
            end
         end else begin
            col_o <= col_o + 8'h01;
         end
      end
   end
endmodule

// ---- verilog/drce_map.vh ----
/*
 Command opcodes, field positions, reset values and limits of the
 display RAM command engine. Definitions only; included by bare name.
*/
`ifndef DRCE_MAP_VH
`define DRCE_MAP_VH

// ==========================================================
// Opcodes
`define DRCE_OP_SET_COL 8'h15
`define DRCE_OP_SET_ROW 8'h75
`define DRCE_OP_WR_RAM 8'h5c
`define DRCE_OP_RD_RAM 8'h5d
`define DRCE_OP_REMAP 8'ha0
`define DRCE_OP_START_LINE 8'ha1
`define DRCE_OP_RECT 8'h84
`define DRCE_OP_CIRCLE 8'h86
`define DRCE_OP_COPY 8'h8a
`define DRCE_OP_DIM 8'h8c
`define DRCE_OP_CLEAR 8'h8e
`define DRCE_OP_FILL 8'h92
`define DRCE_OP_HSCROLL 8'h96

// ==========================================================
// Parameter byte counts
`define DRCE_N_RECT 4'h8
`define DRCE_N_CIRCLE 4'h7
`define DRCE_N_COPY 4'h6
`define DRCE_N_WIN 4'h4
`define DRCE_N_HSCROLL 4'h5
`define DRCE_N_TWO 4'h2
`define DRCE_N_ONE 4'h1
`define DRCE_N_NONE 4'h0

// ==========================================================
// Field positions
`define DRCE_B_INC_VERT 0
`define DRCE_B_COL_REV 1
`define DRCE_B_CLR_SWAP 2
`define DRCE_B_BUS9 3
`define DRCE_B_COM_REV 4
`define DRCE_B_COM_SPLIT 5
`define DRCE_B_DEPTH_LO 6
`define DRCE_B_DEPTH_HI 7
`define DRCE_B_FILL 0
`define DRCE_B_REV_COPY 4
`define DRCE_B_XWRAP 5

// ==========================================================
// Reset values and limits
`define DRCE_RST_REMAP 8'h40
`define DRCE_RST_COL_END 8'h83
`define DRCE_RST_ROW_END 8'h83
`define DRCE_RST_ZERO 8'h00
`define DRCE_MAX_SCROLL 8'h7c
`define DRCE_LINES 8'h84
`define DRCE_LAST_LINE 8'h83

`endif

// ---- verilog/drce_ptr.v ----
/*
 Column/row access pointer of the pixel frame memory window.
 Assumes load and step never collide with each other in one cycle
 except as prioritised here (load wins).
*/
`timescale 1ns/1ps
`include "drce_map.vh"
module drce_ptr (
   // Clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // Control
   input wire load_col_i,
   input wire load_row_i,
   input wire [7:0] col_start_i,
   input wire [7:0] col_end_i,
   input wire [7:0] row_start_i,
   input wire [7:0] row_end_i,
   input wire vert_i,
   input wire step_i,
   // State
   output reg [7:0] col_o,
   output reg [7:0] row_o
);
   wire col_last = (col_o == col_end_i);
   wire row_last = (row_o == row_end_i);

   // ==========================================================
   // Pointer update
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         col_o <= `DRCE_RST_ZERO;
         row_o <= `DRCE_RST_ZERO;
      end else begin
         if (load_col_i) begin
            col_o <= col_start_i;
         end else if (step_i) begin
            if (!vert_i) begin
               if (col_last) begin
                  col_o <= col_start_i;
               end else begin
                  col_o <= col_o + 8'h01;
               end
            end else if (row_last) begin
               if (col_last) begin
                  col_o <= col_start_i;
               end else begin
                  col_o <= col_o + 8'h01;
               end
            end
         end
         if (load_row_i) begin
            row_o <= row_start_i;
         end else if (step_i) begin
            if (vert_i) begin
               if (row_last) begin
                  row_o <= row_start_i;
               end else begin
                  row_o <= row_o + 8'h01;
               end
            end else if (col_last) begin
               if (row_last) begin
                  row_o <= row_start_i;
               end else begin
                  row_o <= row_o + 8'h01;
               end
            end
         end
      end
   end
endmodule

// ---- verilog/drce_top.v ----
/*
 Display RAM command engine: decodes opcode and parameter bytes from
 the host port, holds window, remap, fill and scroll settings, streams
 pixel accesses and runs drawing commands.
 Assumes bytes arrive already synchronous to MCLK_I as one-cycle strobes.
*/
`timescale 1ns/1ps
`include "drce_map.vh"
module drce_top (
   // Clock and reset
   input wire MCLK_I,
   input wire RST_N_I,
   // Host byte port
   input wire BYTE_STB_I,
   input wire DC_I,
   input wire [7:0] BYTE_I,
   input wire RD_STB_I,
   input wire BUS16_I,
   input wire DISPLAY_ON_I,
   // Pixel frame memory access
   input wire [7:0] MEM_RDATA_I,
   output reg MEM_WR_O,
   output reg MEM_RD_O,
   output reg [7:0] MEM_COL_O,
   output reg [7:0] MEM_ROW_O,
   output reg [7:0] MEM_WDATA_O,
   output reg [7:0] RD_DATA_O,
   output reg BUSY_O,
   // Drawing engine
   output reg [7:0] DRAW_OP_O,
   output reg [15:0] LINE_COLOR_O,
   output reg [15:0] FILL_COLOR_O,
   output reg [7:0] CIRCLE_RADIUS_O,
   output reg [7:0] COPY_DST_COL_O,
   output reg [7:0] COPY_DST_ROW_O,
   // Configuration
   output reg FILL_EN_O,
   output reg REV_COPY_O,
   output reg XWRAP_O,
   output reg VERT_INC_O,
   output reg COL_REV_O,
   output reg CLR_SWAP_O,
   output reg BUS9_O,
   output reg COM_REV_O,
   output reg COM_SPLIT_O,
   output reg [1:0] DEPTH_O,
   output reg WIDE_PACK_O,
   output reg [7:0] START_LINE_O,
   // Scroll
   output reg [7:0] HS_OFFSET_O,
   output reg [7:0] HS_ROW_O,
   output reg [7:0] HS_COUNT_O,
   output reg [1:0] HS_SPEED_O,
   output reg HS_RUN_O
);
   localparam ST_IDLE = 2'h0;
   localparam ST_PARAM = 2'h1;
   localparam ST_DRAW = 2'h2;

   localparam AC_NONE = 2'h0;
   localparam AC_WRITE = 2'h1;
   localparam AC_READ = 2'h2;

   reg rst_s1_reg;
   reg rst_n_reg;
   reg [1:0] state_reg;
   reg [1:0] access_reg;
   reg [7:0] op_reg;
   reg [3:0] need_reg;
   reg [3:0] idx_reg;
   reg [7:0] prm_reg [0:7];
   reg [7:0] col_start_reg;
   reg [7:0] col_end_reg;
   reg [7:0] row_start_reg;
   reg [7:0] row_end_reg;
   reg [7:0] remap_reg;
   reg load_col_reg;
   reg load_row_reg;
   reg draw_start_reg;
   wire [7:0] ptr_col;
   wire [7:0] ptr_row;
   wire draw_busy;
   wire [7:0] draw_col;
   wire [7:0] draw_row;
   wire last_prm = (idx_reg == need_reg - 4'h1);
   wire cmd_byte = BYTE_STB_I && !DC_I;
   wire data_byte = BYTE_STB_I && DC_I;
   // Pointer advances on the access edge itself, so back-to-back bytes get fresh addresses
   wire step_now = (state_reg == ST_IDLE) &&
      ((access_reg == AC_WRITE && data_byte) || (access_reg == AC_READ && RD_STB_I));
   integer i;

   // Parameter bytes that follow an opcode
   function [3:0] param_count;
      input [7:0] op;
      begin
         case (op)
            `DRCE_OP_SET_COL: param_count = `DRCE_N_TWO;
            `DRCE_OP_SET_ROW: param_count = `DRCE_N_TWO;
            `DRCE_OP_REMAP: param_count = `DRCE_N_ONE;
            `DRCE_OP_START_LINE: param_count = `DRCE_N_ONE;
            `DRCE_OP_FILL: param_count = `DRCE_N_ONE;
            `DRCE_OP_RECT: param_count = `DRCE_N_RECT;
            `DRCE_OP_CIRCLE: param_count = `DRCE_N_CIRCLE;
            `DRCE_OP_COPY: param_count = `DRCE_N_COPY;
            `DRCE_OP_DIM: param_count = `DRCE_N_WIN;
            `DRCE_OP_CLEAR: param_count = `DRCE_N_WIN;
            `DRCE_OP_HSCROLL: param_count = `DRCE_N_HSCROLL;
            default: param_count = `DRCE_N_NONE;
         endcase
      end
   endfunction

   // Whether an opcode runs the drawing sequencer
   function is_draw;
      input [7:0] op;
      begin
         is_draw = (op == `DRCE_OP_RECT) || (op == `DRCE_OP_CIRCLE) || (op == `DRCE_OP_COPY) ||
            (op == `DRCE_OP_DIM) || (op == `DRCE_OP_CLEAR);
      end
   endfunction

   // ==========================================================
   // Reset release
   always @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rst_s1_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n_reg <= rst_s1_reg;
      end
   end

   // ==========================================================
   // Address pointer and drawing sequencer
   drce_ptr u_ptr (
      .clk_i(MCLK_I),
      .rst_n_i(rst_n_reg),
      .load_col_i(load_col_reg),
      .load_row_i(load_row_reg),
      .col_start_i(col_start_reg),
      .col_end_i(col_end_reg),
      .row_start_i(row_start_reg),
      .row_end_i(row_end_reg),
      .vert_i(remap_reg[`DRCE_B_INC_VERT]),
      .step_i(step_now),
      .col_o(ptr_col),
      .row_o(ptr_row)
   );

   // Bounding box: circle uses centre +/- radius, others the first four bytes
   wire circ = (op_reg == `DRCE_OP_CIRCLE);
   wire [7:0] box_c0 = circ ? ((prm_reg[0] > prm_reg[2]) ? prm_reg[0] - prm_reg[2] : 8'h00) : prm_reg[0];
   wire [7:0] box_r0 = circ ? ((prm_reg[1] > prm_reg[2]) ? prm_reg[1] - prm_reg[2] : 8'h00) : prm_reg[1];
   wire [7:0] box_c1 = circ ? prm_reg[0] + prm_reg[2] : prm_reg[2];
   wire [7:0] box_r1 = circ ? prm_reg[1] + prm_reg[2] : prm_reg[3];

   drce_draw u_draw (
      .clk_i(MCLK_I),
      .rst_n_i(rst_n_reg),
      .start_i(draw_start_reg),
      .c0_i(box_c0),
      .r0_i(box_r0),
      .c1_i(box_c1),
      .r1_i(box_r1),
      .busy_o(draw_busy),
      .col_o(draw_col),
      .row_o(draw_row)
   );

   // ==========================================================
   // Command decoder
   always @(posedge MCLK_I or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         state_reg <= ST_IDLE;
         access_reg <= AC_NONE;
         op_reg <= `DRCE_RST_ZERO;
         need_reg <= `DRCE_N_NONE;
         idx_reg <= 4'h0;
         for (i = 0; i < 8; i = i + 1) begin
            prm_reg[i] <= `DRCE_RST_ZERO;
         end
         col_start_reg <= `DRCE_RST_ZERO;
         col_end_reg <= `DRCE_RST_COL_END;
         row_start_reg <= `DRCE_RST_ZERO;
         row_end_reg <= `DRCE_RST_ROW_END;
         remap_reg <= `DRCE_RST_REMAP;
         load_col_reg <= 1'b0;
         load_row_reg <= 1'b0;
         draw_start_reg <= 1'b0;
         FILL_EN_O <= 1'b0;
         REV_COPY_O <= 1'b0;
         XWRAP_O <= 1'b0;
         START_LINE_O <= `DRCE_RST_ZERO;
         HS_OFFSET_O <= `DRCE_RST_ZERO;
         HS_ROW_O <= `DRCE_RST_ZERO;
         HS_COUNT_O <= `DRCE_RST_ZERO;
         HS_SPEED_O <= 2'h0;
         DRAW_OP_O <= `DRCE_RST_ZERO;
         LINE_COLOR_O <= 16'h0000;
         FILL_COLOR_O <= 16'h0000;
         CIRCLE_RADIUS_O <= `DRCE_RST_ZERO;
         COPY_DST_COL_O <= `DRCE_RST_ZERO;
         COPY_DST_ROW_O <= `DRCE_RST_ZERO;
      end else begin
         load_col_reg <= 1'b0;
         load_row_reg <= 1'b0;
         draw_start_reg <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (cmd_byte) begin
                  op_reg <= BYTE_I;
                  idx_reg <= 4'h0;
                  need_reg <= param_count(BYTE_I);
                  access_reg <= (BYTE_I == `DRCE_OP_WR_RAM) ? AC_WRITE :
                     (BYTE_I == `DRCE_OP_RD_RAM) ? AC_READ : AC_NONE;
                  if (param_count(BYTE_I) != `DRCE_N_NONE) begin
                     state_reg <= ST_PARAM;
                  end
               end
            end
            ST_PARAM: begin
               if (data_byte) begin
                  prm_reg[idx_reg[2:0]] <= BYTE_I;
                  idx_reg <= idx_reg + 4'h1;
                  if (last_prm) begin
                     state_reg <= is_draw(op_reg) ? ST_DRAW : ST_IDLE;
                     draw_start_reg <= is_draw(op_reg);
                     case (op_reg)
                        `DRCE_OP_SET_COL: begin
                           col_start_reg <= prm_reg[0];
                           col_end_reg <= BYTE_I;
                           load_col_reg <= 1'b1;
                        end
                        `DRCE_OP_SET_ROW: begin
                           row_start_reg <= prm_reg[0];
                           row_end_reg <= BYTE_I;
                           load_row_reg <= 1'b1;
                        end
                        `DRCE_OP_REMAP: remap_reg <= BYTE_I;
                        `DRCE_OP_START_LINE: begin
                           if (BYTE_I <= `DRCE_LAST_LINE) begin
                              START_LINE_O <= BYTE_I;
                           end
                        end
                        `DRCE_OP_FILL: begin
                           FILL_EN_O <= BYTE_I[`DRCE_B_FILL];
                           REV_COPY_O <= BYTE_I[`DRCE_B_REV_COPY];
                           XWRAP_O <= BYTE_I[`DRCE_B_XWRAP];
                        end
                        `DRCE_OP_HSCROLL: begin
                           if (prm_reg[0] <= `DRCE_MAX_SCROLL) begin
                              HS_OFFSET_O <= prm_reg[0];
                              HS_ROW_O <= prm_reg[1];
                              HS_COUNT_O <= prm_reg[2];
                              HS_SPEED_O <= BYTE_I[1:0];
                           end
                        end
                        `DRCE_OP_RECT: begin
                           LINE_COLOR_O <= {prm_reg[4], prm_reg[5]};
                           FILL_COLOR_O <= {prm_reg[6], BYTE_I};
                        end
                        `DRCE_OP_CIRCLE: begin
                           CIRCLE_RADIUS_O <= prm_reg[2];
                           LINE_COLOR_O <= {prm_reg[3], prm_reg[4]};
                           FILL_COLOR_O <= {prm_reg[5], BYTE_I};
                        end
                        `DRCE_OP_COPY: begin
                           COPY_DST_COL_O <= prm_reg[4];
                           COPY_DST_ROW_O <= BYTE_I;
                        end
                        default: begin
                        end
                     endcase
                     if (is_draw(op_reg)) begin
                        DRAW_OP_O <= op_reg;
                     end
                  end
               end
            end
            ST_DRAW: begin
               if (!draw_start_reg && !draw_busy) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Pixel stream and outputs
   always @(posedge MCLK_I or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         MEM_WR_O <= 1'b0;
         MEM_RD_O <= 1'b0;
         MEM_COL_O <= `DRCE_RST_ZERO;
         MEM_ROW_O <= `DRCE_RST_ZERO;
         MEM_WDATA_O <= `DRCE_RST_ZERO;
         RD_DATA_O <= `DRCE_RST_ZERO;
         BUSY_O <= 1'b0;
         VERT_INC_O <= 1'b0;
         COL_REV_O <= 1'b0;
         CLR_SWAP_O <= 1'b0;
         BUS9_O <= 1'b0;
         COM_REV_O <= 1'b0;
         COM_SPLIT_O <= 1'b0;
         DEPTH_O <= 2'h1;
         WIDE_PACK_O <= 1'b0;
         HS_RUN_O <= 1'b0;
      end else begin
         MEM_WR_O <= 1'b0;
         MEM_RD_O <= 1'b0;
         BUSY_O <= (state_reg != ST_IDLE) && (state_reg != ST_PARAM);
         if (state_reg == ST_DRAW) begin
            MEM_COL_O <= draw_col;
            MEM_ROW_O <= draw_row;
         end else if (state_reg == ST_IDLE && access_reg == AC_WRITE && data_byte) begin
            MEM_WR_O <= 1'b1;
            MEM_WDATA_O <= BYTE_I;
            MEM_COL_O <= ptr_col;
            MEM_ROW_O <= ptr_row;
         end else if (state_reg == ST_IDLE && access_reg == AC_READ && RD_STB_I) begin
            MEM_RD_O <= 1'b1;
            MEM_COL_O <= ptr_col;
            MEM_ROW_O <= ptr_row;
         end
         if (MEM_RD_O) begin
            RD_DATA_O <= MEM_RDATA_I;
         end
         VERT_INC_O <= remap_reg[`DRCE_B_INC_VERT];
         COL_REV_O <= remap_reg[`DRCE_B_COL_REV];
         CLR_SWAP_O <= remap_reg[`DRCE_B_CLR_SWAP];
         BUS9_O <= remap_reg[`DRCE_B_BUS9];
         COM_REV_O <= remap_reg[`DRCE_B_COM_REV];
         COM_SPLIT_O <= remap_reg[`DRCE_B_COM_SPLIT];
         DEPTH_O <= remap_reg[`DRCE_B_DEPTH_HI:`DRCE_B_DEPTH_LO];
         WIDE_PACK_O <= BUS16_I && remap_reg[`DRCE_B_DEPTH_HI] && remap_reg[`DRCE_B_DEPTH_LO];
         HS_RUN_O <= DISPLAY_ON_I && (HS_OFFSET_O != `DRCE_RST_ZERO);
      end
   end
endmodule
